// file: include/trace_feature_pkg.sv
// Purpose: Constants for the trace source feature, integration and claim registers.
// Assumes: AXI4-Lite slave with 32-bit data and a 4 KiB register window.
// Notes: Field positions are the bit positions of each field's least significant bit.
package trace_feature_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CLAIM_MAX = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_CLAIM_SET = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CLAIM_CLR = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_ITCTRL = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_FEAT3 = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_FEAT2 = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_FEAT1 = 12'h014;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Field positions in the first feature register.
  localparam int F1_ASYNC_POS = 22;
  localparam int F1_SYNC_POS = 20;
  localparam int F1_HWT_POS = 18;
  localparam int F1_PRESC_POS = 16;
  localparam int F1_TRIG_POS = 14;
  localparam int F1_BUS_POS = 10;
  localparam int F1_MARKER_POS = 8;
  localparam int F1_FORCED_POS = 7;
  localparam int F1_RATE_POS = 6;
  localparam int F1_TS_POS = 4;
  localparam int F1_PACKET_FORMAT_KIND_POS = 0;

  // Field positions in the second and third feature registers and the integration control register.
  localparam int F2_KIND_POS = 16;
  localparam int F2_DATA_WIDTH_KIND_POS = 12;
  localparam int F2_TRTYPE_POS = 9;
  localparam int F2_PRIV_POS = 7;
  localparam int F2_FORCE_POS = 6;
  localparam int F2_COMP_POS = 4;
  localparam int F2_PORT_ENABLE_REG_PRESENCE_POS = 2;
  localparam int F2_PORT_TRIGGER_ENABLE_SUPPORT_POS = 0;
  localparam int F3_MASTERS_POS = 0;
  localparam int ITCTRL_IME_POS = 0;

  // Default feature encodings of this build.
  localparam logic [1:0] DEF_ASYNC = 2'h2;
  localparam logic [1:0] DEF_SYNC = 2'h3;
  localparam logic [1:0] DEF_HWT = 2'h2;
  localparam logic [1:0] DEF_PRESC = 2'h1;
  localparam logic [1:0] DEF_TRIG = 2'h2;
  localparam logic [3:0] DEF_BUS = 4'h0;
  localparam logic [1:0] DEF_MARKER = 2'h3;
  localparam logic DEF_FORCED = 1'b1;
  localparam logic DEF_RATE = 1'b1;
  localparam logic [1:0] DEF_TS = 2'h1;
  localparam logic [3:0] DEF_PACKET_FORMAT_KIND = 4'h1;
  localparam logic [1:0] DEF_KIND = 2'h2;
  localparam logic [3:0] DEF_DATA_WIDTH_KIND = 4'h0;
  localparam logic [1:0] DEF_TRTYPE = 2'h2;
  localparam logic [1:0] DEF_PRIV = 2'h2;
  localparam logic DEF_FORCE = 1'b1;
  localparam logic [1:0] DEF_COMP = 2'h3;
  localparam logic DEF_PORT_ENABLE_REG_PRESENCE = 1'b0;
  localparam logic [1:0] DEF_PORT_TRIGGER_ENABLE_SUPPORT = 2'h2;
  localparam logic [15:0] DEF_MASTERS_M1 = 16'h00ff;
  localparam int DEF_CLAIM_BITS = 4;
endpackage

// file: core/trace_feature_claim_regs.sv
// Purpose: Feature, integration mode and claim tag registers of a trace source.
// Assumes: One clock, synchronous active-low reset, AXI4-Lite master on the same clock.
// Notes: Feature registers are read-only constants chosen by parameters, except the port enable presence bit, which is a package constant.
//
// What this block does
// R1: Two-bit support fields report none, absent, present.
// R2: Sync enable field reports four support cases.
// R3: Trigger shot field reports multi or single.
// R4: Bus kind reports base or trigger bus.
// R5: Marker register field reports presence and mode.
// R6: Forced stamp and rate writable single bits.
// R7: Timestamp kind: differential, absolute or none.
// R8: Protocol field one; reserved bits read zero.
// R9: Port kind: basic, extended or both.
// R10: Data width kind: 32 or 64 bits.
// R11: Transaction kind: invariant, guaranteed or both.
// R12: Privilege filter field and port force bit.
// R13: Compression field: none, always or programmable.
// R14: Port enable present; trigger enable field.
// R15: Third register holds master count minus one.
// R16: Integration bit resets zero; upper bits reserved.
// R17: Software sets integration only while unit off.
// R18: Integration bit reads back what was written.
// R19: Agents claim by set, check, release, retry.
// R20: Claim bits never gate any register access.
// R21: At least four claim bits; upper bits zero.
// R22: Clear reads claims; one clears; reset zero.
// R23: Set register ones set; zeros change nothing.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module trace_feature_claim_regs #(
  parameter int CLAIM_BITS = trace_feature_pkg::DEF_CLAIM_BITS,
  parameter logic [1:0] ASYNC_SUPPORT = trace_feature_pkg::DEF_ASYNC,
  parameter logic [1:0] SYNC_SUPPORT = trace_feature_pkg::DEF_SYNC,
  parameter logic [1:0] HWT_SUPPORT = trace_feature_pkg::DEF_HWT,
  parameter logic [1:0] PRESC_SUPPORT = trace_feature_pkg::DEF_PRESC,
  parameter logic [1:0] TRIG_SUPPORT = trace_feature_pkg::DEF_TRIG,
  parameter logic [3:0] BUS_KIND = trace_feature_pkg::DEF_BUS,
  parameter logic [1:0] MARKER_SUPPORT = trace_feature_pkg::DEF_MARKER,
  parameter logic FORCED_SUPPORT = trace_feature_pkg::DEF_FORCED,
  parameter logic RATE_WRITABLE = trace_feature_pkg::DEF_RATE,
  parameter logic [1:0] TS_KIND = trace_feature_pkg::DEF_TS,
  parameter logic [3:0] PACKET_FORMAT_KIND_KIND = trace_feature_pkg::DEF_PACKET_FORMAT_KIND,
  parameter logic [1:0] PORT_KIND = trace_feature_pkg::DEF_KIND,
  parameter logic [3:0] DATA_WIDTH_KIND_KIND = trace_feature_pkg::DEF_DATA_WIDTH_KIND,
  parameter logic [1:0] TRTYPE_KIND = trace_feature_pkg::DEF_TRTYPE,
  parameter logic [1:0] PRIV_SUPPORT = trace_feature_pkg::DEF_PRIV,
  parameter logic FORCE_SUPPORT = trace_feature_pkg::DEF_FORCE,
  parameter logic [1:0] COMP_SUPPORT = trace_feature_pkg::DEF_COMP,
  parameter logic [1:0] PORT_TRIGGER_ENABLE_SUPPORT_SUPPORT = trace_feature_pkg::DEF_PORT_TRIGGER_ENABLE_SUPPORT,
  parameter logic [15:0] MASTERS_M1 = trace_feature_pkg::DEF_MASTERS_M1
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel.
  input wire logic [trace_feature_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input wire logic [trace_feature_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel.
  input wire logic [trace_feature_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [trace_feature_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Block state.
  output logic integration_mode,
  output logic [CLAIM_BITS-1:0] claim_bits
);
  import trace_feature_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] ra;
    logic aw_held;
    logic [ADDR_W-1:0] wa;
    logic w_held;
    logic [DATA_W-1:0] wd;
    logic [3:0] ws;
    logic [CLAIM_BITS-1:0] claim;
    logic integration_mode_bit;
  } state_s;

  state_s q_r;
  state_s q_nxt;
  logic wr_fire;
  logic [DATA_W-1:0] w_eff;
  logic [CLAIM_BITS-1:0] w_claim;
  logic [DATA_W-1:0] feat1_word;
  logic [DATA_W-1:0] feat2_word;
  logic [DATA_W-1:0] feat3_word;

  ////////////////////////////////////////////////////////////////////////////
  // Feature words. Every position not named here reads as zero.

  assign feat1_word = (32'(ASYNC_SUPPORT) << F1_ASYNC_POS) // R1
    | (32'(SYNC_SUPPORT) << F1_SYNC_POS) // R2
    | (32'(HWT_SUPPORT) << F1_HWT_POS) // R1
    | (32'(PRESC_SUPPORT) << F1_PRESC_POS) // R1
    | (32'(TRIG_SUPPORT) << F1_TRIG_POS) // R3
    | (32'(BUS_KIND) << F1_BUS_POS) // R4
    | (32'(MARKER_SUPPORT) << F1_MARKER_POS) // R5
    | (32'(FORCED_SUPPORT) << F1_FORCED_POS) // R6
    | (32'(RATE_WRITABLE) << F1_RATE_POS) // R6
    | (32'(TS_KIND) << F1_TS_POS) // R7
    | (32'(PACKET_FORMAT_KIND_KIND) << F1_PACKET_FORMAT_KIND_POS); // R8

  assign feat2_word = (32'(PORT_KIND) << F2_KIND_POS) // R9
    | (32'(DATA_WIDTH_KIND_KIND) << F2_DATA_WIDTH_KIND_POS) // R10
    | (32'(TRTYPE_KIND) << F2_TRTYPE_POS) // R11
    | (32'(PRIV_SUPPORT) << F2_PRIV_POS) // R12
    | (32'(FORCE_SUPPORT) << F2_FORCE_POS) // R12
    | (32'(COMP_SUPPORT) << F2_COMP_POS) // R13
    | (32'(DEF_PORT_ENABLE_REG_PRESENCE) << F2_PORT_ENABLE_REG_PRESENCE_POS) // R14
    | (32'(PORT_TRIGGER_ENABLE_SUPPORT_SUPPORT) << F2_PORT_TRIGGER_ENABLE_SUPPORT_POS); // R14

  assign feat3_word = 32'(MASTERS_M1) << F3_MASTERS_POS; // R15

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [DATA_W-1:0] strb_mask(input logic [3:0] s);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction

  assign w_eff = q_r.wd & strb_mask(q_r.ws);
  assign w_claim = w_eff[CLAIM_BITS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state. Claim state enters no handshake term, so access is never gated.

  always_comb begin
    q_nxt = q_r;
    wr_fire = 1'b0;
    if (s_axi_awvalid && q_r.awready) begin
      q_nxt.aw_held = 1'b1;
      q_nxt.wa = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_r.wready) begin
      q_nxt.w_held = 1'b1;
      q_nxt.wd = s_axi_wdata;
      q_nxt.ws = s_axi_wstrb;
    end
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
    end
    if (q_r.aw_held && q_r.w_held && !q_r.bvalid) begin // R20
      wr_fire = 1'b1;
      q_nxt.aw_held = 1'b0;
      q_nxt.w_held = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = RESP_OKAY;
      if (hit(q_r.wa, OFF_CLAIM_SET)) begin
        q_nxt.claim = q_r.claim | w_claim; // R23
      end else if (hit(q_r.wa, OFF_CLAIM_CLR)) begin
        q_nxt.claim = q_r.claim & ~w_claim; // R22
      end else if (hit(q_r.wa, OFF_ITCTRL)) begin
        if (q_r.ws[0]) begin
          q_nxt.integration_mode_bit = q_r.wd[ITCTRL_IME_POS]; // R18
        end
      end else if (!(hit(q_r.wa, OFF_FEAT1) || hit(q_r.wa, OFF_FEAT2) || hit(q_r.wa, OFF_FEAT3))) begin
        q_nxt.bresp = RESP_DECERR;
      end
    end
    q_nxt.awready = !q_nxt.aw_held && !q_nxt.bvalid;
    q_nxt.wready = !q_nxt.w_held && !q_nxt.bvalid;
    if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q_r.arready) begin // R20
      q_nxt.rvalid = 1'b1;
      q_nxt.ra = s_axi_araddr;
      q_nxt.rresp = RESP_OKAY;
      if (hit(s_axi_araddr, OFF_CLAIM_SET) || hit(s_axi_araddr, OFF_CLAIM_CLR)) begin
        q_nxt.rdata = 32'(q_r.claim); // R21 R22
      end else if (hit(s_axi_araddr, OFF_ITCTRL)) begin
        q_nxt.rdata = 32'(q_r.integration_mode_bit) << ITCTRL_IME_POS; // R16 R18
      end else if (hit(s_axi_araddr, OFF_FEAT1)) begin
        q_nxt.rdata = feat1_word;
      end else if (hit(s_axi_araddr, OFF_FEAT2)) begin
        q_nxt.rdata = feat2_word;
      end else if (hit(s_axi_araddr, OFF_FEAT3)) begin
        q_nxt.rdata = feat3_word;
      end else begin
        q_nxt.rdata = '0;
        q_nxt.rresp = RESP_DECERR;
      end
    end
    q_nxt.arready = !q_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0; // R16 R22
    end else begin
      q_r <= q_nxt;
    end
  end

  assign s_axi_awready = q_r.awready;
  assign s_axi_wready = q_r.wready;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_arready = q_r.arready;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rresp = q_r.rresp;
  assign s_axi_rdata = q_r.rdata;
  assign integration_mode = q_r.integration_mode_bit;
  assign claim_bits = q_r.claim;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence rd_of(logic [ADDR_W-1:0] off);
    q_r.rvalid && hit(q_r.ra, off);
  endsequence

  sequence wr_of(logic [ADDR_W-1:0] off);
    wr_fire && hit(q_r.wa, off);
  endsequence

  feat1_value_a: assert property (rd_of(OFF_FEAT1) |-> q_r.rdata[31:24] == 8'h00 && q_r.rdata == feat1_word) // R8
    else $error("first feature register reads wrong");
  feat2_value_a: assert property (rd_of(OFF_FEAT2) |-> q_r.rdata[31:18] == 14'h0000 && q_r.rdata[11] == 1'b0 && q_r.rdata[3] == 1'b0 && q_r.rdata[2] == 1'b0) // R14
    else $error("second feature register reserved bits set");
  feat3_value_a: assert property (rd_of(OFF_FEAT3) |-> q_r.rdata == {16'h0000, MASTERS_M1}) // R15
    else $error("master count reads wrong");
  ime_readback_a: assert property (rd_of(OFF_ITCTRL) |-> q_r.rdata == {31'h00000000, integration_mode}) // R18
    else $error("integration bit read back differs");
  ime_write_a: assert property (wr_of(OFF_ITCTRL) ##0 q_r.ws[0] |=> integration_mode == $past(q_r.wd[0])) // R18
    else $error("integration bit not written");
  claim_set_a: assert property (wr_of(OFF_CLAIM_SET) |=> claim_bits == ($past(claim_bits) | $past(w_claim))) // R23
    else $error("claim set wrong");
  claim_clr_a: assert property (wr_of(OFF_CLAIM_CLR) |=> claim_bits == ($past(claim_bits) & ~$past(w_claim))) // R22
    else $error("claim clear wrong");
  claim_read_a: assert property (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, OFF_CLAIM_CLR)
    |=> s_axi_rdata == 32'($past(claim_bits))) // R21
    else $error("claim read wrong");
  no_gating_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) // R20
    else $error("read not answered next cycle");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) // R20
    else $error("write not answered two cycles later");

endmodule // trace_feature_claim_regs

`default_nettype wire

// file: test/trace_feature_claim_regs_test.sv
// Purpose: Self-checking bench for the trace feature, integration and claim registers.
// Assumes: Default parameters, four claim bits, AXI4-Lite master on a 40 MHz clock.
// Notes: Only mismatches and the verdict are printed.
`timescale 1ns/1ps
`default_nettype none

module trace_feature_claim_regs_test;
  import trace_feature_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, integration_mode;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [DEF_CLAIM_BITS-1:0] claim_bits;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  trace_feature_claim_regs dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .integration_mode(integration_mode), .claim_bits(claim_bits));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s response expected %h seen %h", what, exp, got);
    end
  endtask

  // The response ready lines stay high, so each answer is taken when it shows.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk_word(what, exp, d);
    chk_resp(what, RESP_OKAY, r);
  endtask

  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    axi_write(a, d, s, r);
    chk_resp("write", RESP_OKAY, r);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state();
    chk_word("claim pins", 32'h0, 32'(claim_bits));
    chk_word("integration pin", 32'h0, 32'(integration_mode));
    rd_chk("claim set", OFF_CLAIM_SET, 32'h0);
    rd_chk("claim clear", OFF_CLAIM_CLR, 32'h0);
    rd_chk("integration reg", OFF_ITCTRL, 32'h0);
  endtask

  task automatic t_features();
    logic [31:0] f1, f2;
    f1 = (32'(DEF_ASYNC) << F1_ASYNC_POS) | (32'(DEF_SYNC) << F1_SYNC_POS) | (32'(DEF_HWT) << F1_HWT_POS)
       | (32'(DEF_PRESC) << F1_PRESC_POS) | (32'(DEF_TRIG) << F1_TRIG_POS) | (32'(DEF_BUS) << F1_BUS_POS)
       | (32'(DEF_MARKER) << F1_MARKER_POS) | (32'(DEF_FORCED) << F1_FORCED_POS)
       | (32'(DEF_RATE) << F1_RATE_POS) | (32'(DEF_TS) << F1_TS_POS) | (32'(DEF_PACKET_FORMAT_KIND) << F1_PACKET_FORMAT_KIND_POS);
    f2 = (32'(DEF_KIND) << F2_KIND_POS) | (32'(DEF_DATA_WIDTH_KIND) << F2_DATA_WIDTH_KIND_POS)
       | (32'(DEF_TRTYPE) << F2_TRTYPE_POS) | (32'(DEF_PRIV) << F2_PRIV_POS)
       | (32'(DEF_FORCE) << F2_FORCE_POS) | (32'(DEF_COMP) << F2_COMP_POS)
       | (32'(DEF_PORT_ENABLE_REG_PRESENCE) << F2_PORT_ENABLE_REG_PRESENCE_POS) | (32'(DEF_PORT_TRIGGER_ENABLE_SUPPORT) << F2_PORT_TRIGGER_ENABLE_SUPPORT_POS);
    rd_chk("feature one", OFF_FEAT1, f1);
    rd_chk("feature two", OFF_FEAT2, f2);
    rd_chk("feature three", OFF_FEAT3, {16'h0, DEF_MASTERS_M1});
    wr_ok(OFF_FEAT1, 32'hffffffff, 4'hf);
    wr_ok(OFF_FEAT3, 32'h0, 4'hf);
    rd_chk("feature one kept", OFF_FEAT1, f1);
    rd_chk("feature three kept", OFF_FEAT3, {16'h0, DEF_MASTERS_M1});
  endtask

  task automatic t_integration();
    wr_ok(OFF_ITCTRL, 32'h1, 4'he);
    rd_chk("integration masked", OFF_ITCTRL, 32'h0);
    // The trace unit is never switched on here, so setting integration mode is allowed.
    wr_ok(OFF_ITCTRL, 32'hffffffff, 4'hf);
    rd_chk("integration set", OFF_ITCTRL, 32'h1);
    chk_word("integration pin", 32'h1, 32'(integration_mode));
    wr_ok(OFF_ITCTRL, 32'h0, 4'hf);
    rd_chk("integration clear", OFF_ITCTRL, 32'h0);
  endtask

  task automatic t_claims();
    wr_ok(OFF_CLAIM_SET, 32'h5, 4'hf);
    chk_word("claim pins", 32'h5, 32'(claim_bits));
    wr_ok(OFF_CLAIM_SET, 32'h2, 4'hf);
    wr_ok(OFF_CLAIM_SET, 32'hfffffff0, 4'hf);
    wr_ok(OFF_CLAIM_SET, 32'h8, 4'he);
    rd_chk("claim set", OFF_CLAIM_SET, 32'h7);
    wr_ok(OFF_ITCTRL, 32'h1, 4'h1);
    rd_chk("integration while claimed", OFF_ITCTRL, 32'h1);
    wr_ok(OFF_ITCTRL, 32'h0, 4'h1);
    wr_ok(OFF_CLAIM_CLR, 32'h1, 4'hf);
    wr_ok(OFF_CLAIM_CLR, 32'hfffffff0, 4'hf);
    rd_chk("claim clear", OFF_CLAIM_CLR, 32'h6);
    // An agent on bit three sees others present and backs off.
    wr_ok(OFF_CLAIM_SET, 32'h8, 4'hf);
    rd_chk("contended claim", OFF_CLAIM_CLR, 32'he);
    wr_ok(OFF_CLAIM_CLR, 32'h8, 4'hf);
    chk_word("claim pins", 32'h6, 32'(claim_bits));
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(12'h018, d, r);
    chk_word("unmapped data", 32'h0, d);
    chk_resp("unmapped read", RESP_DECERR, r);
    axi_write(12'h018, 32'hf, 4'hf, r);
    chk_resp("unmapped write", RESP_DECERR, r);
    rd_chk("claims after unmapped", OFF_CLAIM_SET, 32'h6);
  endtask

  task automatic t_mid_reset();
    wr_ok(OFF_ITCTRL, 32'h1, 4'hf);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_word("claims after reset", 32'h0, 32'(claim_bits));
    chk_word("integration after reset", 32'h0, 32'(integration_mode));
    rd_chk("claim after reset", OFF_CLAIM_CLR, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_state();
    t_features();
    t_integration();
    t_claims();
    t_unmapped();
    t_mid_reset();
    conclude();
  end
endmodule // trace_feature_claim_regs_test

`default_nettype wire
